// File: common/conv_pkg.sv
/*
  Shared constants, types and decode helpers for the converter control
  block. Assumes a byte-wide register view carried in the low lane of a
  32-bit classic Wishbone bus.
*/
package conv_pkg;

  localparam int RESULT_W = 12;
  localparam int CHAN_N = 8;
  localparam int DIV_SEL_W = 3;
  localparam int DIV_CNT_W = 7;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_RESULT_LOW = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CONTROL_MAIN = 8'h08;
  localparam logic [7:0] OFS_SOURCE_CLOCK = 8'h0C;
  localparam logic [7:0] OFS_GAIN_SENSOR = 8'h10;
  localparam logic [7:0] OFS_PIN_ANALOG = 8'h14;

  // conv_control_main fields
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_ALIGN_BIT = 4;
  localparam int CTRL_CHAN_LSB = 0;

  // conv_source_clock_select fields
  localparam int SRC_SEL_LSB = 5;
  localparam int SRC_VREF_LSB = 3;
  localparam int SRC_DIV_LSB = 0;

  // reset values
  localparam logic [7:0] RST_CONTROL_MAIN = 8'h00;
  localparam logic [7:0] RST_SOURCE_CLOCK = 8'h00;
  localparam logic [7:0] RST_GAIN_SENSOR = 8'h00;
  localparam logic [7:0] RST_PIN_ANALOG = 8'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;

  // input source codes
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_AMP0 = 3'h1;
  localparam logic [2:0] SRC_AMP1 = 3'h2;
  localparam logic [2:0] SRC_GROUND = 3'h3;
  localparam logic [2:0] SRC_SUPPLY = 3'h4;
  localparam logic [2:0] SRC_REF_AMP = 3'h5;
  localparam logic [3:0] CHAN_LAST = 4'h7;

  // conversion timing in converter clock ticks / system cycles
  localparam logic [2:0] SAMPLE_TICKS = 3'h4;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } sar_state_t;

  typedef struct packed {
    logic powered;
    logic ext_path;
    logic [2:0] int_src;
    logic [7:0] pin_switch;
  } analog_route_t;

  typedef struct packed {
    logic [7:0] gpio_off;
    logic [7:0] pullup_off;
  } pin_share_t;

  function automatic logic is_ext_source(input logic [2:0] s);
    return (s == SRC_EXT) || (s > SRC_REF_AMP);
  endfunction

endpackage

// File: verilog/conv_clock_divider.sv
/*
  Converter clock prescaler: a one-cycle tick every 2**sel system cycles.
  Assumes sel is stable while a conversion runs.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider
  import conv_pkg::*;
#(
  parameter int SEL_W = DIV_SEL_W,
  parameter int CNT_W = DIV_CNT_W
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // control
  input wire logic run_in,
  input wire logic [SEL_W-1:0] div_sel_in,
  // tick
  output logic tick_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  assign last = CNT_W'((1 << div_sel_in) - 1);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      if (!run_in) begin
        count <= '0;
        tick_out <= 1'b0;
      end else if (count >= last) begin
        count <= '0;
        tick_out <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick_out <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/conv_sar_engine.sv
/*
  Successive-approximation sequencer: sample phase, then one bit on the
  first converter tick after each SETTLE_CYCLES-cycle settle, MSB first.
  Assumes an analog comparator whose output is
  high when the input is at or above the trial code.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_sar_engine
  import conv_pkg::*;
#(
  parameter int W = RESULT_W
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // control
  input wire logic enable_in,
  input wire logic start_in,
  input wire logic tick_in,
  input wire logic cmp_in,
  // status and data
  output logic busy_out,
  output logic sample_out,
  output logic done_out,
  output logic [W-1:0] trial_out,
  output logic [W-1:0] result_out
);

  sar_state_t state;
  logic cmp_meta;
  logic cmp_sync;
  logic [3:0] bit_idx;
  logic [2:0] sample_cnt;
  logic [1:0] settle_cnt;
  logic [W-1:0] next_trial;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else if (clk_en_in) begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
    end
  end

  always_comb begin
    next_trial = trial_out;
    if (!cmp_sync) begin
      next_trial[bit_idx] = 1'b0;
    end
    if (bit_idx != 4'h0) begin
      next_trial[bit_idx - 4'h1] = 1'b1;
    end
  end

  // comparator path is synchronised, so each trial settles a few cycles
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      busy_out <= 1'b0;
      sample_out <= 1'b0;
      done_out <= 1'b0;
      bit_idx <= 4'h0;
      sample_cnt <= 3'h0;
      settle_cnt <= 2'h0;
      trial_out <= '0;
      result_out <= '0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      if (!enable_in) begin
        state <= ST_IDLE;
        busy_out <= 1'b0;
        sample_out <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_in) begin
              state <= ST_SAMPLE;
              busy_out <= 1'b1;
              sample_out <= 1'b1;
              sample_cnt <= 3'h0;
            end
          end
          ST_SAMPLE: begin
            if (tick_in) begin
              if (sample_cnt == SAMPLE_TICKS - 3'h1) begin
                state <= ST_CONVERT;
                sample_out <= 1'b0;
                bit_idx <= 4'(W - 1);
                trial_out <= W'(1) << (W - 1);
                settle_cnt <= 2'h0;
              end else begin
                sample_cnt <= sample_cnt + 3'h1;
              end
            end
          end
          ST_CONVERT: begin
            if (settle_cnt != SETTLE_CYCLES) begin
              settle_cnt <= settle_cnt + 2'h1;
            end else if (tick_in) begin
              trial_out <= next_trial;
              settle_cnt <= 2'h0;
              if (bit_idx == 4'h0) begin
                state <= ST_IDLE;
                result_out <= next_trial;
                busy_out <= 1'b0;
                done_out <= 1'b1;
              end else begin
                bit_idx <= bit_idx - 4'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            busy_out <= 1'b0;
            sample_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/adc_register_control.sv
/*
  Register-level control of a single 12-bit successive-approximation
  converter: Wishbone classic register slave, source routing, pin-sharing
  controls, start/busy handling and result formatting.
  Assumes one system clock, an analog comparator and switch fabric
  outside, and a bus master that keeps each request until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_register_control
  import conv_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // analog front end
  input wire logic cmp_in,
  output analog_route_t route_out,
  output logic [1:0] vref_sel_out,
  output logic [7:0] gain_sensor_out,
  output logic sample_out,
  output logic [RESULT_W-1:0] trial_out,
  // pin sharing
  output pin_share_t pins_out,
  // event toward the interrupt controller
  output logic conv_irq_out
);

  // register state
  logic ctrl_start;
  logic conv_enable;
  logic result_align_sel;
  logic [3:0] ext_channel_sel;
  logic [7:0] conv_source_clock_select;
  logic [7:0] conv_gain_sensor_control;
  logic [7:0] pin_analog_sel;
  logic [RESULT_W-1:0] result;

  // derived fields
  logic [2:0] input_source_sel;
  logic [1:0] vref_sel;
  logic [2:0] conv_clock_div_sel;

  // bus decode
  logic req;
  logic wr_fire;
  logic start_launch;
  logic [7:0] read_byte;

  // engine wiring
  logic conv_tick;
  logic conv_busy_flag;
  logic conv_done;
  logic [RESULT_W-1:0] engine_result;
  logic ext_path;
  logic [CHAN_N-1:0] pin_switch;

  assign input_source_sel = conv_source_clock_select[SRC_SEL_LSB +: 3];
  assign vref_sel = conv_source_clock_select[SRC_VREF_LSB +: 2];
  assign conv_clock_div_sel = conv_source_clock_select[SRC_DIV_LSB +: 3];

  // formats one result byte for the current alignment
  function automatic logic [7:0] result_byte(
    input logic [RESULT_W-1:0] d,
    input logic align,
    input logic high
  );
    logic [7:0] b;
    b = 8'h00;
    if (!align) begin
      if (high) begin
        b = d[11:4];
      end else begin
        b = {d[3:0], 4'h0};
      end
    end else begin
      if (high) begin
        b = {4'h0, d[11:8]};
      end else begin
        b = d[7:0];
      end
    end
    return b;
  endfunction

  // register read mux, shared by the read path
  function automatic logic [7:0] reg_read(input logic [7:0] adr);
    logic [7:0] v;
    v = 8'h00;
    case (adr)
      OFS_RESULT_LOW: begin
        v = result_byte(result, result_align_sel, 1'b0);
      end
      OFS_RESULT_HIGH: begin
        v = result_byte(result, result_align_sel, 1'b1);
      end
      OFS_CONTROL_MAIN: begin
        v[CTRL_START_BIT] = ctrl_start;
        v[CTRL_BUSY_BIT] = conv_busy_flag;
        v[CTRL_ENABLE_BIT] = conv_enable;
        v[CTRL_ALIGN_BIT] = result_align_sel;
        v[CTRL_CHAN_LSB +: 4] = ext_channel_sel;
      end
      OFS_SOURCE_CLOCK: begin
        v = conv_source_clock_select;
      end
      OFS_GAIN_SENSOR: begin
        v = conv_gain_sensor_control;
      end
      OFS_PIN_ANALOG: begin
        v = pin_analog_sel;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  assign req = wb_cyc_in && wb_stb_in;
  // writes land on the edge where the master sees ack
  assign wr_fire = req && wb_we_in && wb_ack_out && wb_sel_in[0];
  assign read_byte = reg_read(wb_adr_in);

  // falling write of the start bit while it was high
  assign start_launch = wr_fire && (wb_adr_in == OFS_CONTROL_MAIN) &&
    ctrl_start && !wb_dat_in[CTRL_START_BIT];

  // bus acknowledge: one wait state, dropped the cycle after
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
    end else if (clk_en_in) begin
      wb_ack_out <= req && !wb_ack_out;
    end
  end

  // read data captured with ack; unmapped words read zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (req && !wb_ack_out && !wb_we_in) begin
        wb_dat_out <= {24'h00_0000, read_byte};
      end
    end
  end

  // conv_control_main; busy bit has no writable storage here
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_start <= RST_CONTROL_MAIN[CTRL_START_BIT];
      conv_enable <= RST_CONTROL_MAIN[CTRL_ENABLE_BIT];
      result_align_sel <= RST_CONTROL_MAIN[CTRL_ALIGN_BIT];
      ext_channel_sel <= RST_CONTROL_MAIN[CTRL_CHAN_LSB +: 4];
    end else if (clk_en_in) begin
      if (wr_fire && wb_adr_in == OFS_CONTROL_MAIN) begin
        ctrl_start <= wb_dat_in[CTRL_START_BIT];
        conv_enable <= wb_dat_in[CTRL_ENABLE_BIT];
        result_align_sel <= wb_dat_in[CTRL_ALIGN_BIT];
        ext_channel_sel <= wb_dat_in[CTRL_CHAN_LSB +: 4];
      end
    end
  end

  // source/clock select register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_source_clock_select <= RST_SOURCE_CLOCK;
    end else if (clk_en_in) begin
      if (wr_fire && wb_adr_in == OFS_SOURCE_CLOCK) begin
        conv_source_clock_select <= wb_dat_in[7:0];
      end
    end
  end

  // gain/sensor register, passed to the analog side untouched
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_gain_sensor_control <= RST_GAIN_SENSOR;
    end else if (clk_en_in) begin
      if (wr_fire && wb_adr_in == OFS_GAIN_SENSOR) begin
        conv_gain_sensor_control <= wb_dat_in[7:0];
      end
    end
  end

  // pin-sharing selection, one bit per external analog pin
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_analog_sel <= RST_PIN_ANALOG;
    end else if (clk_en_in) begin
      if (wr_fire && wb_adr_in == OFS_PIN_ANALOG) begin
        pin_analog_sel <= wb_dat_in[7:0];
      end
    end
  end

  // result only moves on a completed conversion
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result <= RST_RESULT;
    end else if (clk_en_in) begin
      if (conv_done && conv_enable) begin
        result <= engine_result;
      end
    end
  end

  // completion event, one cycle, toward the interrupt controller
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_irq_out <= 1'b0;
    end else if (clk_en_in) begin
      conv_irq_out <= conv_done;
    end
  end

  conv_clock_divider #(
    .SEL_W(DIV_SEL_W),
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .run_in(conv_enable),
    .div_sel_in(conv_clock_div_sel),
    .tick_out(conv_tick)
  );

  // single engine serves every source in turn
  conv_sar_engine #(
    .W(RESULT_W)
  ) u_sar (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .enable_in(conv_enable),
    .start_in(start_launch),
    .tick_in(conv_tick),
    .cmp_in(cmp_in),
    .busy_out(conv_busy_flag),
    .sample_out(sample_out),
    .done_out(conv_done),
    .trial_out(trial_out),
    .result_out(engine_result)
  );

  // source routing
  assign ext_path = conv_enable && is_ext_source(input_source_sel);

  // a pin switch closes only for a valid code on an analog-selected pin
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_N; gi++) begin : g_pin
      assign pin_switch[gi] = ext_path &&
        (ext_channel_sel <= CHAN_LAST) &&
        (ext_channel_sel == 4'(gi)) &&
        pin_analog_sel[gi];
    end
  endgenerate

  always_comb begin
    route_out.powered = conv_enable;
    route_out.ext_path = ext_path;
    // internal code is only meaningful while the external path is off
    route_out.int_src = ext_path ? SRC_EXT : input_source_sel;
    route_out.pin_switch = pin_switch;
  end

  always_comb begin
    pins_out.gpio_off = pin_analog_sel;
    pins_out.pullup_off = pin_analog_sel;
  end

  assign vref_sel_out = vref_sel;
  assign gain_sensor_out = conv_gain_sensor_control;

endmodule
`default_nettype wire

// File: tb/adc_ctrl_asserts.sv
/*
  Concurrent checks on the ports of adc_register_control.
  Assumes one system clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_asserts
  import conv_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // register bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // converter side
  input wire analog_route_t route_out,
  input wire logic sample_out,
  input wire pin_share_t pins_out,
  input wire logic conv_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    && clk_en_in |=> wb_ack_out) else $error("request not acknowledged");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_out |->
    $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
  read_upper_a: assert property (wb_ack_out |->
    wb_dat_out[31:8] == 24'h0) else $error("upper read bits not zero");
  irq_pulse_a: assert property (conv_irq_out |=> !conv_irq_out)
    else $error("completion pulse too long");
  irq_sample_a: assert property (conv_irq_out |-> !sample_out)
    else $error("completion during sampling");
  pin_pair_a: assert property (route_out.pin_switch != 8'h00 |->
    (route_out.pin_switch & ~pins_out.pullup_off) == 8'h00)
    else $error("switched pin keeps its pull-high");
  switch_pin_a: assert property (route_out.pin_switch != 8'h00 |->
    $onehot(route_out.pin_switch) && route_out.powered &&
    (route_out.pin_switch & ~pins_out.gpio_off) == 8'h00)
    else $error("bad input switch pattern");
  off_sample_a: assert property (!route_out.powered [*2] |->
    !sample_out) else $error("sampling while disabled");

  cover property (conv_irq_out);
  cover property (wb_ack_out && $past(wb_cyc_in));
  cover property ($rose(sample_out));
endmodule

bind adc_register_control adc_ctrl_asserts chk_u (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .route_out(route_out),
  .sample_out(sample_out),
  .pins_out(pins_out),
  .conv_irq_out(conv_irq_out)
);
`default_nettype wire

// File: tb/tb_top.sv
/*
  Self-checking bench for adc_register_control: Wishbone tasks, then
  register, conversion, disable and routing sequences.
  Assumes an ideal comparator that tracks a target code.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top
  import conv_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic smp;
  logic irq;
  logic [11:0] trial;
  logic [11:0] target = 12'h000;
  logic [7:0] gain;
  logic [7:0] rd;
  logic [7:0] exp_sw;
  analog_route_t route;
  pin_share_t pins;
  int n_mismatch = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int smp_cnt = 0;

  adc_register_control dut_u (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .cmp_in(target >= trial), .route_out(route),
    .vref_sel_out(), .gain_sensor_out(gain), .sample_out(smp),
    .trial_out(trial), .pins_out(pins), .conv_irq_out(irq));

  always #25 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (irq === 1'b1) irq_cnt++;
    if (smp === 1'b1) smp_cnt++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    `CHK("wb_ack", 1'b1, ack)
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask

  // start pulse as two writes, then poll busy under a bound
  task automatic convert(input logic [11:0] t, input logic [7:0] ctl,
                         input logic [7:0] eh, input logic [7:0] el);
    int n;
    n = 0;
    target <= t;
    bus(1'b1, 8'h08, ctl | 8'h80);
    bus(1'b1, 8'h08, ctl);
    rdchk("busy_set", 8'h08, ctl | 8'h40);
    do begin
      bus(1'b0, 8'h08, 8'h00);
      n++;
    end while (rd[6] !== 1'b0 && n < 400);
    `CHK("busy_clear", ctl, rd)
    rdchk("res_high", 8'h04, eh);
    rdchk("res_low", 8'h00, el);
  endtask

  initial begin
    #(50 * 60000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk("reset", 8'(i * 4), 8'h00);
    bus(1'b1, 8'h18, 8'h5A);
    rdchk("unmapped", 8'h18, 8'h00);
    bus(1'b1, 8'h08, 8'h40);
    rdchk("busy_write", 8'h08, 8'h00);
    bus(1'b1, 8'h10, 8'hA5);
    rdchk("gain", 8'h10, 8'hA5);
    `CHK("gain_out", 8'hA5, gain)
    convert(12'hA5C, 8'h23, 8'hA5, 8'hC0);
    `CHK("irq_count", 1, irq_cnt)
    // slower converter clock stretches the four sampling ticks
    bus(1'b1, 8'h0C, 8'h02);
    smp_cnt = 0;
    convert(12'h3C7, 8'h35, 8'h03, 8'hC7);
    `CHK("sample_len", 1'b1, smp_cnt >= 13 && smp_cnt <= 17)
    bus(1'b1, 8'h08, 8'h90);
    bus(1'b1, 8'h08, 8'h10);
    repeat (100) @(posedge ref_clk_in);
    rdchk("off_busy", 8'h08, 8'h10);
    `CHK("off_irq", 2, irq_cnt)
    `CHK("off_power", 1'b0, route.powered)
    rdchk("keep_high", 8'h04, 8'h03);
    rdchk("keep_low", 8'h00, 8'hC7);
    bus(1'b1, 8'h14, 8'hFF);
    // the write lands on the ack edge, so look once it has settled
    @(negedge ref_clk_in);
    `CHK("pin_share", 16'hFFFF, pins)
    for (int s = 0; s < 8; s++) begin
      for (int c = 3; c < 12; c += 6) begin
        bus(1'b1, 8'h0C, {3'(s), 5'h00});
        bus(1'b1, 8'h08, {4'h2, 4'(c)});
        @(negedge ref_clk_in);
        exp_sw = (s == 0 || s > 5) && c < 8 ? 8'h01 << c : 8'h00;
        `CHK("pin_switch", exp_sw, route.pin_switch)
        `CHK("int_src", ((s == 0 || s > 5) ? 3'h0 : 3'(s)), route.int_src)
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
